// ==== rtl/cefr_pkg.sv ====
// Constants and carrier types for the charger event flag register bank.
// Assumes a single internal clock and an active-low power-on reset.
package cefr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CEFR_OFS_CHARGE_EVENT_FLAGS_TWO = 8'h24;
  localparam logic [7:0] CEFR_OFS_THERMISTOR_ZONE_FLAGS = 8'h25;
  localparam logic [7:0] CEFR_OFS_PROTECTION_FAULT_FLAGS = 8'h26;
  localparam logic [7:0] CEFR_FLAG_RESET = 8'h00;
  localparam logic [7:0] CEFR_UNMAPPED_DATA = 8'h00;
  localparam int CEFR_REG_W = 8;
  localparam int CEFR_ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, charge event flags two
  localparam int CEFR_BIT_LINE_DETECT_COMPLETE = 6;
  localparam int CEFR_BIT_ADC_DONE = 5;
  localparam int CEFR_BIT_FAST_CHARGE_EXPIRY = 3;
  localparam int CEFR_BIT_TRICKLE_EXPIRY = 2;
  localparam int CEFR_BIT_PRECHARGE_EXPIRY = 1;
  localparam int CEFR_BIT_TOP_OFF_EXPIRY = 0;

  // Field positions, thermistor zone flags
  localparam int CEFR_BIT_THERMISTOR_COLD = 3;
  localparam int CEFR_BIT_THERMISTOR_COOL = 2;
  localparam int CEFR_BIT_THERMISTOR_WARM = 1;
  localparam int CEFR_BIT_THERMISTOR_HOT = 0;

  // Field positions, protection fault flags
  localparam int CEFR_BIT_BATTERY_CURRENT_REG = 7;
  localparam int CEFR_BIT_BUS_OVERVOLTAGE = 6;
  localparam int CEFR_BIT_BATTERY_OVERVOLTAGE = 5;
  localparam int CEFR_BIT_BUS_OVERCURRENT = 4;
  localparam int CEFR_BIT_BATTERY_OVERCURRENT = 3;
  localparam int CEFR_BIT_CONVERTER_OVERCURRENT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  localparam int CEFR_COND_W = 17;

  // Internal conditions, all levels from the analog and control sections
  typedef struct packed {
    logic line_detect_done;
    logic adc_conv_done;
    logic adc_one_shot;
    logic fast_charge_expired;
    logic trickle_expired;
    logic precharge_expired;
    logic top_off_expired;
    logic ts_cold;
    logic ts_cool;
    logic ts_warm;
    logic ts_hot;
    logic battery_current_reg;
    logic bus_overvoltage;
    logic battery_overvoltage;
    logic bus_overcurrent;
    logic battery_overcurrent;
    logic converter_overcurrent;
  } cefr_cond_t;

  typedef struct packed {
    logic strobe;
    logic [CEFR_ADDR_W-1:0] addr;
  } cefr_rd_req_t;

  typedef struct packed {
    logic valid;
    logic [CEFR_REG_W-1:0] data;
  } cefr_rd_rsp_t;

  typedef struct packed {
    logic [CEFR_REG_W-1:0] charge_event_flags_two;
    logic [CEFR_REG_W-1:0] thermistor_zone_flags;
    logic [CEFR_REG_W-1:0] protection_fault_flags;
  } cefr_flags_t;

endpackage : cefr_pkg

// ==== rtl/cefr_edge_sync.sv ====
// Two-stage synchroniser bank with edge detection on the settled level.
// Assumes inputs are asynchronous levels; edges are one-cycle pulses.
`timescale 1ns/10ps
module cefr_edge_sync #(
  parameter int W = 17
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;
  } cefr_sync_state_t;

  cefr_sync_state_t state_r;
  cefr_sync_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = i_level;
    state_nxt.stable = state_r.meta;
    state_nxt.last = state_r.stable;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_level = state_r.stable;
  assign o_rise = state_r.stable & ~state_r.last;
  assign o_fall = ~state_r.stable & state_r.last;

endmodule : cefr_edge_sync

// ==== rtl/cefr_flag_bank.sv ====
// Event flag bank: three read-only, clear-on-read 8-bit flag registers.
// Assumes the serial interface engine presents reads as a one-cycle strobe
// with an address on the same clock; conditions arrive asynchronously.
`timescale 1ns/10ps
module cefr_flag_bank (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire cefr_pkg::cefr_cond_t i_cond,
  input wire cefr_pkg::cefr_rd_req_t i_rd_req,
  output cefr_pkg::cefr_rd_rsp_t o_rd_rsp,
  output cefr_pkg::cefr_flags_t o_flags,
  output logic o_any_flag
);
  import cefr_pkg::*;

  typedef struct packed {
    cefr_flags_t flags;
    cefr_rd_rsp_t rsp;
    logic any_flag;
  } cefr_bank_state_t;

  cefr_bank_state_t state_r;
  cefr_bank_state_t state_nxt;

  logic [CEFR_COND_W-1:0] cond_level;
  logic [CEFR_COND_W-1:0] cond_rise;
  logic [CEFR_COND_W-1:0] cond_fall;
  cefr_cond_t lvl;
  cefr_cond_t rise;
  cefr_cond_t fall;

  logic [CEFR_REG_W-1:0] set_two;
  logic [CEFR_REG_W-1:0] set_therm;
  logic [CEFR_REG_W-1:0] set_fault;
  logic rd_two;
  logic rd_therm;
  logic rd_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Conditions come from analog comparators and timers, so all are synced
  cefr_edge_sync #(
    .W(CEFR_COND_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_level(i_cond),
    .o_level(cond_level),
    .o_rise(cond_rise),
    .o_fall(cond_fall)
  );

  assign lvl = cond_level;
  assign rise = cond_rise;
  assign fall = cond_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Set wins over a clear in the same cycle, so no event is lost
  function automatic logic [CEFR_REG_W-1:0] latch_flags(
    input logic [CEFR_REG_W-1:0] cur,
    input logic [CEFR_REG_W-1:0] set,
    input logic clr
  );
    logic [CEFR_REG_W-1:0] kept;
    kept = clr ? CEFR_FLAG_RESET : cur;
    return kept | set;
  endfunction : latch_flags

  function automatic logic addr_hit(
    input cefr_rd_req_t req,
    input logic [CEFR_ADDR_W-1:0] ofs
  );
    return req.strobe && (req.addr == ofs);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Event decode into register bit positions
  always_comb begin
    set_two = '0;
    set_therm = '0;
    set_fault = '0;

    // Done level rising means detection has just completed
    set_two[CEFR_BIT_LINE_DETECT_COMPLETE] = rise.line_detect_done;
    // Continuous-mode conversions never raise this flag
    set_two[CEFR_BIT_ADC_DONE] = rise.adc_conv_done & lvl.adc_one_shot;
    set_two[CEFR_BIT_FAST_CHARGE_EXPIRY] = rise.fast_charge_expired;
    set_two[CEFR_BIT_TRICKLE_EXPIRY] = rise.trickle_expired;
    set_two[CEFR_BIT_PRECHARGE_EXPIRY] = rise.precharge_expired;
    set_two[CEFR_BIT_TOP_OFF_EXPIRY] = rise.top_off_expired;

    // Zone bits and current regulation count a crossing in either direction; other faults only a rise
    set_therm[CEFR_BIT_THERMISTOR_COLD] = rise.ts_cold | fall.ts_cold;
    set_therm[CEFR_BIT_THERMISTOR_COOL] = rise.ts_cool | fall.ts_cool;
    set_therm[CEFR_BIT_THERMISTOR_WARM] = rise.ts_warm | fall.ts_warm;
    set_therm[CEFR_BIT_THERMISTOR_HOT] = rise.ts_hot | fall.ts_hot;

    set_fault[CEFR_BIT_BATTERY_CURRENT_REG] =
      rise.battery_current_reg | fall.battery_current_reg;
    set_fault[CEFR_BIT_BUS_OVERVOLTAGE] = rise.bus_overvoltage;
    set_fault[CEFR_BIT_BATTERY_OVERVOLTAGE] = rise.battery_overvoltage;
    set_fault[CEFR_BIT_BUS_OVERCURRENT] = rise.bus_overcurrent;
    set_fault[CEFR_BIT_BATTERY_OVERCURRENT] = rise.battery_overcurrent;
    set_fault[CEFR_BIT_CONVERTER_OVERCURRENT] = rise.converter_overcurrent;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; there is no write path at all
  assign rd_two = addr_hit(i_rd_req, CEFR_OFS_CHARGE_EVENT_FLAGS_TWO);
  assign rd_therm = addr_hit(i_rd_req, CEFR_OFS_THERMISTOR_ZONE_FLAGS);
  assign rd_fault = addr_hit(i_rd_req, CEFR_OFS_PROTECTION_FAULT_FLAGS);

  always_comb begin
    state_nxt = state_r;

    // Data returned is the value before this cycle's clear and set
    state_nxt.rsp.valid = i_rd_req.strobe;
    if (rd_two) begin
      state_nxt.rsp.data = state_r.flags.charge_event_flags_two;
    end else if (rd_therm) begin
      state_nxt.rsp.data = state_r.flags.thermistor_zone_flags;
    end else if (rd_fault) begin
      state_nxt.rsp.data = state_r.flags.protection_fault_flags;
    end else if (i_rd_req.strobe) begin
      state_nxt.rsp.data = CEFR_UNMAPPED_DATA;
    end

    // Reserved bits never receive a set, so they stay zero
    state_nxt.flags.charge_event_flags_two =
      latch_flags(state_r.flags.charge_event_flags_two, set_two, rd_two);
    state_nxt.flags.thermistor_zone_flags =
      latch_flags(state_r.flags.thermistor_zone_flags, set_therm, rd_therm);
    state_nxt.flags.protection_fault_flags =
      latch_flags(state_r.flags.protection_fault_flags, set_fault, rd_fault);

    state_nxt.any_flag = |state_nxt.flags;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r.flags.charge_event_flags_two <= CEFR_FLAG_RESET;
      state_r.flags.thermistor_zone_flags <= CEFR_FLAG_RESET;
      state_r.flags.protection_fault_flags <= CEFR_FLAG_RESET;
      state_r.rsp <= '0;
      state_r.any_flag <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_rd_rsp = state_r.rsp;
  assign o_flags = state_r.flags;
  assign o_any_flag = state_r.any_flag;

endmodule : cefr_flag_bank

// ==== testbench/cefr_flag_bank_properties.sv ====
// Concurrent checks on the flag bank ports.
// Assumes condition levels are held at least one clock.
`timescale 1ns/10ps
module cefr_flag_bank_properties (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire cefr_pkg::cefr_cond_t i_cond,
  input wire cefr_pkg::cefr_rd_req_t i_rd_req,
  input wire cefr_pkg::cefr_rd_rsp_t o_rd_rsp,
  input wire cefr_pkg::cefr_flags_t o_flags,
  input wire logic o_any_flag
);
  import cefr_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire rd26 = i_rd_req.strobe && i_rd_req.addr == CEFR_OFS_PROTECTION_FAULT_FLAGS;
  wire [7:0] pf = o_flags.protection_fault_flags;
  property p_ans; i_rd_req.strobe |=> o_rd_rsp.valid; endproperty
  property p_cause; o_rd_rsp.valid |-> $past(i_rd_req.strobe); endproperty
  property p_unmap;
    i_rd_req.strobe && (i_rd_req.addr < 8'h24 || i_rd_req.addr > 8'h26)
      |=> o_rd_rsp.data == CEFR_UNMAPPED_DATA;
  endproperty
  property p_rsv;
    {o_flags.charge_event_flags_two[7], o_flags.charge_event_flags_two[4],
      o_flags.thermistor_zone_flags[7:4], pf[1:0]} == 8'h00;
  endproperty
  property p_any; o_any_flag == |o_flags; endproperty
  // Only a read of the fault register may drop a fault bit
  property p_latch; |($past(pf) & ~pf) |-> $past(rd26); endproperty
  property p_rd26; rd26 |=> o_rd_rsp.data == $past(pf); endproperty
  property p_bovp; $rose(i_cond.bus_overvoltage) |-> ##3 pf[6]; endproperty
  property p_adc;
    $rose(o_flags.charge_event_flags_two[5]) |-> $past(i_cond.adc_one_shot, 3);
  endproperty
  property p_hot; $fell(i_cond.ts_hot) |-> ##3 o_flags.thermistor_zone_flags[0]; endproperty
  property p_ibat; $fell(i_cond.battery_current_reg) |-> ##3 pf[7]; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  a_cause: assert property (p_cause) else $error("stray valid");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_any: assert property (p_any) else $error("any flag wrong");
  a_latch: assert property (p_latch) else $error("flag lost");
  a_rd26: assert property (p_rd26) else $error("fault read data");
  a_bovp: assert property (p_bovp) else $error("bus ovp not set");
  a_adc: assert property (p_adc) else $error("adc flag not gated");
  a_hot: assert property (p_hot) else $error("hot exit not set");
  a_ibat: assert property (p_ibat) else $error("reg exit not set");
  c_rd: cover property (rd26 ##1 o_rd_rsp.data != 8'h00);
  c_any: cover property ($rose(o_any_flag));
  c_hot: cover property ($fell(i_cond.ts_hot));
endmodule : cefr_flag_bank_properties
bind cefr_flag_bank cefr_flag_bank_properties i_props (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_cond(i_cond), .i_rd_req(i_rd_req), .o_rd_rsp(o_rd_rsp), .o_flags(o_flags),
  .o_any_flag(o_any_flag));

// ==== testbench/cefr_host_model.sv ====
// Host reader: one-cycle read strobes into the flag bank.
// Assumes calls start after reset release.
`timescale 1ns/10ps
module cefr_host_model (
  input wire logic i_clk,
  input wire cefr_pkg::cefr_rd_rsp_t i_rsp,
  output cefr_pkg::cefr_rd_req_t o_req
);
  import cefr_pkg::*;
  initial o_req = '0;
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge i_clk);
    o_req <= {1'b1, addr};
    @(posedge i_clk);
    o_req.strobe <= 1'b0;
    // Valid stands one cycle only; look mid-cycle, clear of the edges
    @(negedge i_clk);
    // A missing answer must never pass as data
    data = (i_rsp.valid === 1'b1) ? i_rsp.data : 8'hxx;
  endtask : read
endmodule : cefr_host_model

// ==== testbench/cefr_flag_bank_test.sv ====
// Self-checking bench for the flag bank against a queue model.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
module cefr_flag_bank_test;
  import cefr_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  cefr_cond_t cond = '0;
  cefr_rd_req_t req;
  cefr_rd_rsp_t rsp;
  cefr_flags_t flags;
  logic any_flag;
  logic [31:0] lfsr = 32'hc28a2d10;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int exp_q[$] = '{0, 0, 0};
  always #25 i_clk = ~i_clk;
  cefr_flag_bank i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cond(cond), .i_rd_req(req),
    .o_rd_rsp(rsp), .o_flags(flags), .o_any_flag(any_flag));
  cefr_host_model i_host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_flags(input cefr_flags_t got, input logic got_any);
    logic [23:0] exp;
    exp = {exp_q[0][7:0], exp_q[1][7:0], exp_q[2][7:0]};
    n_compared++;
    if (got !== exp || got_any !== |exp) begin
      error_cnt++;
      $display("mismatch at %0t: flags %h any %b expected %h", $time, got, got_any, exp);
    end
  endtask : cmp_flags
  // Flag levels are looked at mid-cycle, away from the edge that launches them
  task automatic check_flags;
    @(negedge i_clk);
    cmp_flags(flags, any_flag);
  endtask : check_flags
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check_reg(input int k);
    logic [7:0] d;
    i_host.read(8'h24 + k[7:0], d);
    cmp(d, exp_q[k][7:0]);
    exp_q[k] = 0;
  endtask : check_reg
  // Flags are ORed in, so events between polls accumulate
  task automatic model(input cefr_cond_t o, input cefr_cond_t n);
    cefr_cond_t r;
    cefr_cond_t c;
    r = n & ~o;
    c = n ^ o;
    exp_q[0] |= {r.line_detect_done, r.adc_conv_done & n.adc_one_shot, 1'b0,
      r.fast_charge_expired, r.trickle_expired, r.precharge_expired, r.top_off_expired};
    exp_q[1] |= {c.ts_cold, c.ts_cool, c.ts_warm, c.ts_hot};
    exp_q[2] |= {c.battery_current_reg, r.bus_overvoltage, r.battery_overvoltage,
      r.bus_overcurrent, r.battery_overcurrent, r.converter_overcurrent, 2'b00};
  endtask : model
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    cefr_cond_t old;
    logic [7:0] d;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    check_flags();
    for (int k = 0; k < 3; k++) check_reg(k);
    i_host.read(8'h27, d);
    cmp(d, CEFR_UNMAPPED_DATA);
    for (int i = 0; i < 400; i++) begin
      old = cond;
      for (int b = 0; b < 17; b++) lfsr = lfsr_next(lfsr);
      @(posedge i_clk);
      cond <= lfsr[16:0];
      repeat (4) @(posedge i_clk);
      model(old, cefr_cond_t'(lfsr[16:0]));
      check_flags();
      // Skipped polls leave flags pending for a later read
      for (int k = 0; k < 3; k++) if (lfsr[20 + k]) check_reg(k);
      if (i % 50 == 0) check_reg(1);
    end
    // Mid-run reset with conditions held: levels high at release count as edges
    @(posedge i_clk);
    i_rstn <= 1'b0;
    exp_q = '{0, 0, 0};
    check_flags();
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    model('0, cond);
    repeat (4) @(posedge i_clk);
    check_flags();
    for (int k = 0; k < 3; k++) check_reg(k);
    give_verdict();
  end
endmodule : cefr_flag_bank_test
